// [design/lps_pkg.sv]
package lps_pkg;
  // word width and buffer depth defaults
  localparam int LPS_DATA_W = 8;
  localparam int LPS_FIFO_DEPTH = 16;
  // length of each pin synchroniser chain
  localparam int LPS_SYNC_LEN = 3;
  // values after reset
  localparam logic [LPS_DATA_W-1:0] LPS_WORD_RST = 8'h00;
  localparam logic LPS_PIN_LOW_RST = 1'b0;
  localparam logic LPS_OE_N_RST = 1'b1;
  // stage positions: first stage takes serial input, last stage drives the pin
  localparam int LPS_FIRST_STAGE = 0;
  localparam int LPS_LAST_STAGE = LPS_DATA_W - 1;
endpackage : lps_pkg

// [design/lps_fifo.sv]
`timescale 1ns/1ns
module lps_fifo
  import lps_pkg::*;
#(
  parameter int WIDTH = LPS_DATA_W,
  parameter int DEPTH = LPS_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // drain side accepts
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } lps_fifo_st_t;

  lps_fifo_st_t q;
  lps_fifo_st_t d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((q.wr_ptr[AW] != q.rd_ptr[AW]) && (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]));
  assign out_valid = (q.wr_ptr != q.rd_ptr);
  assign out_data = mem[q.rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer update
  always_comb begin
    d = q;
    if (push) begin
      d.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = q.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : lps_fifo

// [design/lps_shift_reg.sv]
`timescale 1ns/1ns
// Functional notes
// - A rising edge of the latch clock captures the eight parallel input bits into the data latch; the code buffers the word until the latch is free.
// - With shift/load select high, each rising shift clock edge moves the serial input bit into the register.
// - With shift/load select low, the serial input bit is ignored.
// - With shift/load select low, the shift register takes the data latch contents instead of shifting.
// - On each shift the last stage's bit leaves on the serial output and the last stage takes the previous bit.
// - The serial output pin always presents the last stage through a three-state driver.
// - The serial output is driven while the active-low enable is low and released while it is high.
// - The output enable has no effect on the data latch or the shift register.
module lps_shift_reg
  import lps_pkg::*;
#(
  parameter int DATA_W = LPS_DATA_W,
  parameter int FIFO_DEPTH = LPS_FIFO_DEPTH
) (
  input wire logic clk, // system clock, 25 MHz
  input wire logic rstn, // async reset, active low
  input wire logic [DATA_W-1:0] parallel_data_in, // parallel inputs, bit 0 is A
  input wire logic latch_clk_in, // latch clock pin
  input wire logic shift_clk_in, // shift clock pin
  input wire logic shift_load_sel, // high shift, low parallel load
  input wire logic serial_data_in, // serial data pin
  input wire logic output_en_n, // output enable, active low
  output logic serial_data_out, // last stage value
  output logic serial_data_out_oe_n, // pin driver enable, low drives
  output logic latch_ready // buffer can take another latch word
);
  typedef struct packed {
    logic [LPS_SYNC_LEN-1:0] lclk_s;
    logic [LPS_SYNC_LEN-1:0] sclk_s;
    logic [LPS_SYNC_LEN-1:0] mode_s;
    logic [LPS_SYNC_LEN-1:0] oe_s;
    logic [LPS_SYNC_LEN-1:0] sin_s;
    logic [LPS_SYNC_LEN-1:0][DATA_W-1:0] pd_s;
    logic lclk_f;
    logic sclk_f;
    logic mode_f;
    logic oe_f;
    logic sin_f;
    logic [DATA_W-1:0] pd_f;
    logic [DATA_W-1:0] latch;
    logic latch_vld;
    logic latch_used;
    logic [DATA_W-1:0] sr;
    logic sdo;
    logic sdo_oe_n;
    logic lat_rdy;
  } lps_st_t;

  lps_st_t q;
  lps_st_t d;
  logic lclk_rise;
  logic sclk_rise;
  logic mode_rise;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [DATA_W-1:0] fifo_out_data;

  // filtered level follows once second and third stage agree
  function automatic logic filt(input logic [LPS_SYNC_LEN-1:0] s, input logic cur);
    filt = (s[1] == s[2]) ? s[2] : cur;
  endfunction : filt

  // latch words queue here until the data latch is free
  lps_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(lclk_rise),
    .in_ready(fifo_in_ready),
    .in_data(d.pd_f),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // latch takes a new word when empty or already handed to the register
  assign fifo_out_ready = !q.latch_vld || q.latch_used;

  // next state
  always_comb begin
    d = q;
    // synchroniser chains, first stage read only by the second
    d.lclk_s = {q.lclk_s[LPS_SYNC_LEN-2:0], latch_clk_in};
    d.sclk_s = {q.sclk_s[LPS_SYNC_LEN-2:0], shift_clk_in};
    d.mode_s = {q.mode_s[LPS_SYNC_LEN-2:0], shift_load_sel};
    d.oe_s = {q.oe_s[LPS_SYNC_LEN-2:0], output_en_n};
    d.sin_s = {q.sin_s[LPS_SYNC_LEN-2:0], serial_data_in};
    d.pd_s[0] = parallel_data_in;
    for (int i = 1; i < LPS_SYNC_LEN; i++) begin
      d.pd_s[i] = q.pd_s[i-1];
    end
    // agreement filters
    d.lclk_f = filt(q.lclk_s, q.lclk_f);
    d.sclk_f = filt(q.sclk_s, q.sclk_f);
    d.mode_f = filt(q.mode_s, q.mode_f);
    d.oe_f = filt(q.oe_s, q.oe_f);
    d.sin_f = filt(q.sin_s, q.sin_f);
    for (int b = 0; b < DATA_W; b++) begin
      d.pd_f[b] = (q.pd_s[1][b] == q.pd_s[2][b]) ? q.pd_s[2][b] : q.pd_f[b];
    end
    // edges of the filtered levels
    lclk_rise = d.lclk_f && !q.lclk_f;
    sclk_rise = d.sclk_f && !q.sclk_f;
    mode_rise = d.mode_f && !q.mode_f;
    // data latch refill from the buffer
    if (fifo_out_valid && fifo_out_ready) begin
      d.latch = fifo_out_data;
      d.latch_vld = 1'b1;
      d.latch_used = 1'b0;
    end else if (mode_rise && q.latch_vld) begin
      d.latch_used = 1'b1;
    end
    // shift register: parallel load or serial shift
    if (!d.mode_f) begin
      d.sr = q.latch;
    end else if (sclk_rise) begin
      d.sr = {q.sr[LPS_LAST_STAGE-1:LPS_FIRST_STAGE], d.sin_f};
    end
    // pin outputs; enable touches nothing else
    d.sdo = d.sr[LPS_LAST_STAGE];
    d.sdo_oe_n = d.oe_f;
    d.lat_rdy = fifo_in_ready;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.oe_s <= {LPS_SYNC_LEN{LPS_OE_N_RST}};
      q.oe_f <= LPS_OE_N_RST;
      q.sdo_oe_n <= LPS_OE_N_RST;
      q.latch <= LPS_WORD_RST;
      q.sr <= LPS_WORD_RST;
      q.sdo <= LPS_PIN_LOW_RST;
    end else begin
      q <= d;
    end
  end

  assign serial_data_out = q.sdo;
  assign serial_data_out_oe_n = q.sdo_oe_n;
  assign latch_ready = q.lat_rdy;
endmodule : lps_shift_reg

// [tb/lps_host_model.sv]
`timescale 1ns/1ns
// controller model: sets every pin after a clock edge
module lps_host_model (
  input wire logic clk, // clock
  output logic [7:0] par_o, // word
  output logic lat_o, // latch clock
  output logic sclk_o, // shift clock
  output logic mode_o, // high shift
  output logic sin_o, // serial data
  output logic oe_n_o // enable, low drives
);
  // idle levels at time zero
  initial begin
    par_o = 8'h00;
    {lat_o, sclk_o, mode_o, sin_o, oe_n_o} = 5'h00;
  end
  // levels stand n cycles so the pin filters see them
  task automatic put(input logic [7:0] d, input logic [4:0] c, input int n);
    @(posedge clk);
    par_o <= d;
    {lat_o, sclk_o, mode_o, sin_o, oe_n_o} <= c;
    repeat (n - 1) @(posedge clk);
  endtask : put
endmodule : lps_host_model

// [tb/lps_shift_reg_props.sv]
`timescale 1ns/1ns
// pin checks
module lps_shift_reg_props
  import lps_pkg::*;
#(parameter int DATA_W = LPS_DATA_W, parameter int FIFO_DEPTH = LPS_FIFO_DEPTH) (
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic [DATA_W-1:0] parallel_data_in, // word
  input wire logic latch_clk_in, // latch clock
  input wire logic shift_clk_in, // shift clock
  input wire logic shift_load_sel, // mode
  input wire logic serial_data_in, // serial in
  input wire logic output_en_n, // enable
  input wire logic serial_data_out, // last stage
  input wire logic serial_data_out_oe_n, // driver enable
  input wire logic latch_ready // space left
);
  // quiet: no edge on the active clock
  wire shift_idle = shift_load_sel && !shift_clk_in;
  wire load_idle = !shift_load_sel && !latch_clk_in;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  oe_drive_a: assert property ((!output_en_n)[*6] |=> !serial_data_out_oe_n) else $error("not driven");
  oe_release_a: assert property (output_en_n[*6] |=> serial_data_out_oe_n) else $error("not released");
  reset_state_a: assert property ($rose(rstn) |-> serial_data_out_oe_n && !serial_data_out && !latch_ready)
    else $error("bad reset state");
  ready_up_a: assert property ($rose(rstn) |=> latch_ready) else $error("not ready");
  shift_quiet_a: assert property (shift_idle[*8] ##1 shift_idle[*3] |-> $stable(serial_data_out))
    else $error("moved while idle");
  load_quiet_a: assert property (load_idle[*8] ##1 load_idle[*3] |-> $stable(serial_data_out))
    else $error("moved in load");
  shift_cause_a: assert property ($changed(serial_data_out) && shift_load_sel && $past(shift_load_sel, 8)
    |-> $past(shift_clk_in, 3)) else $error("shift without clock");
  refuse_cause_a: assert property ($fell(latch_ready) |-> $past(latch_clk_in, 3))
    else $error("ready fell alone");
  // main scenarios
  cover property ($changed(serial_data_out) && shift_load_sel);
  cover property ($fell(latch_ready));
  cover property (serial_data_out_oe_n && shift_load_sel);
endmodule : lps_shift_reg_props

bind lps_shift_reg lps_shift_reg_props #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH)) lps_shift_reg_props_inst (.*);

// [tb/lps_shift_reg_tb_top.sv]
`timescale 1ns/1ns
// queues expected pin bits, compares them at each shift clock rise while shift/load select is high
module lps_shift_reg_tb_top;
  logic clk, rstn, lat, sclk, mode, sin, oe_n, sdo, sdo_oe_n, ready;
  logic [7:0] par;
  logic expq[$];
  int fails, checks;
  wire qpin = sdo_oe_n ? 1'bz : sdo; // resolved pin
  lps_shift_reg lps_shift_reg_inst (.clk(clk), .rstn(rstn), .parallel_data_in(par), .latch_clk_in(lat),
    .shift_clk_in(sclk), .shift_load_sel(mode), .serial_data_in(sin), .output_en_n(oe_n),
    .serial_data_out(sdo), .serial_data_out_oe_n(sdo_oe_n), .latch_ready(ready));
  lps_host_model lps_host_model_inst (.clk(clk), .par_o(par), .lat_o(lat), .sclk_o(sclk), .mode_o(mode),
    .sin_o(sin), .oe_n_o(oe_n));
  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // latch a word while shift clock and serial data also move
  task automatic load(input logic [7:0] d);
    logic b;
    b = 1'($urandom);
    lps_host_model_inst.put(d, {3'b000, b, 1'b0}, 4);
    lps_host_model_inst.put(d, {3'b110, ~b, 1'b0}, 4);
  endtask : load
  // word bits leave last stage first, then the serial bits follow
  task automatic session(input logic [7:0] d, input logic o);
    logic [15:0] s;
    s = 16'($urandom);
    lps_host_model_inst.put(8'h00, {4'b0000, o}, 12);
    for (int j = 0; j < 16; j++) begin
      // flip the enable mid-stream; the remaining bits must be untouched
      if (j == 8) begin
        lps_host_model_inst.put(8'h00, {4'b0010, ~o}, 12);
        lps_host_model_inst.put(8'h00, {4'b0010, o}, 12);
      end
      expq.push_back(o ? 1'bz : (j < 8 ? d[7 - j] : s[j - 8]));
      lps_host_model_inst.put(8'h00, {3'b001, s[j], o}, 4);
      lps_host_model_inst.put(8'h00, {3'b011, s[j], o}, 6);
    end
    lps_host_model_inst.put(8'h00, {4'b0010, ~o}, 12);
  endtask : session
  // compare before each shift lands
  always @(posedge sclk) begin
    if (mode === 1'b1) chk(qpin, expq.pop_front());
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
  // fill past the buffer, then drain in order
  initial begin
    logic [7:0] w[lps_pkg::LPS_FIFO_DEPTH + 2];
    rstn = 1'b0;
    void'($urandom(54));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    lps_host_model_inst.put(8'h00, 5'h00, 6);
    foreach (w[i]) begin
      w[i] = 8'($urandom);
      load(w[i]);
    end
    chk(ready, 8'h00);
    foreach (w[i]) if (i <= lps_pkg::LPS_FIFO_DEPTH) session(w[i], i == 2);
    lps_host_model_inst.put(8'h00, 5'h00, 12);
    chk(ready, 8'h01);
    chk(8'(expq.size()), 8'h00);
    end_sim();
  end
endmodule : lps_shift_reg_tb_top
